// ===== design/asp_pkg.sv
// Purpose: Shared constants and types for the converter serial port block.
// Assumes: One 24-bit word per register access after an 8-bit command byte.
// Notes:   Register select codes and field positions are local choices.
package asp_pkg;

  localparam int CMD_W   = 8;
  localparam int DATA_W  = 24;
  localparam int CNT_W   = 5;
  localparam int RW_BIT  = 6;
  localparam int SEL_LSB = 0;
  localparam int SEL_W   = 3;
  localparam int SYNC_W  = 4;

  localparam logic [SEL_W-1:0] SEL_COMM   = 3'h0;
  localparam logic [SEL_W-1:0] SEL_DATA   = 3'h1;
  localparam logic [SEL_W-1:0] SEL_MODE   = 3'h2;
  localparam logic [SEL_W-1:0] SEL_FILTER = 3'h3;
  localparam logic [SEL_W-1:0] SEL_DAC    = 3'h4;
  localparam logic [SEL_W-1:0] SEL_CAL    = 3'h5;

  localparam logic [CMD_W-1:0]  COMM_RST  = 8'h00;
  localparam logic [DATA_W-1:0] MODE_RST  = 24'h000000;
  localparam logic [DATA_W-1:0] FILT_RST  = 24'h000000;
  localparam logic [DATA_W-1:0] DAC_RST   = 24'h000000;
  localparam logic [DATA_W-1:0] CAL_RST   = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RST  = 24'h000000;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_RD  = 2'b01,
    PH_WR  = 2'b10
  } asp_phase_t;

  typedef struct packed {
    logic [DATA_W-1:0] mode;
    logic [DATA_W-1:0] filter;
    logic [DATA_W-1:0] dac;
    logic [DATA_W-1:0] cal;
  } asp_cfg_t;

  typedef struct packed {
    logic              pend;
    logic              valid;
    logic              cal_start;
    logic              cal_done;
    logic [DATA_W-1:0] data;
  } asp_conv_t;

endpackage : asp_pkg

// ===== design/asp_sync.sv
// Purpose: Two-flop synchroniser for pins entering the system clock domain.
// Assumes: Inputs are slow levels relative to clk_sys.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module asp_sync #(
  parameter int               W     = 1,
  parameter logic [W-1:0]     RST_V = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= RST_V;
      q       <= RST_V;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : asp_sync

// ===== design/asp_port.sv
// Purpose: Serial host port with result-ready flag and standby halt.
// Assumes: Host drives sclk idle high; data sampled on its rising edge.
// Notes:   All pins pass asp_sync before any logic reads them.
`timescale 1ns/1ps
// Behaviour
// RULE1 - Standby low halts serial and result logic entirely; dout_oe_ff still follows chip select in standby.
// RULE2 - Registers keep their contents through standby.
// RULE3 - Chip select low enables transfers; high idles the port.
// RULE4 - Chip select tied low still works as a three-wire port.
// RULE5 - Host may frame each transfer with chip select.
// RULE6 - Fresh conversion word drives result-ready low.
// RULE7 - Result-ready rises after a complete data word read only.
// RULE8 - Unread result: ready rises before update, low after it.
// RULE9 - Host avoids data reads while result-ready is high.
// RULE10 - Calibration start raises ready; completion lowers it.
// RULE11 - Output shifter loads from the register the select bits name.
// RULE12 - Input shifter word goes to the register the select bits name.
// RULE13 - One bit per serial clock cycle while selected.
module asp_port (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             sclk_pin,
  input  wire logic             cs_n_pin,
  input  wire logic             din_pin,
  input  wire logic             standby_n_pin,
  input  wire asp_pkg::asp_conv_t conv,
  output logic                  dout_ff,
  output logic                  dout_oe_ff,
  output logic                  rdy_n_ff,
  output logic                  run_ff,
  output asp_pkg::asp_cfg_t     cfg_ff
);

  localparam int DW = asp_pkg::DATA_W;
  localparam int CW = asp_pkg::CNT_W;

  logic [asp_pkg::SYNC_W-1:0] pins_s;
  logic                       sclk_s;
  logic                       cs_n_s;
  logic                       din_s;
  logic                       run_s;

  asp_sync #(
    .W     (asp_pkg::SYNC_W),
    .RST_V (4'hb)
  ) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       ({sclk_pin, cs_n_pin, din_pin, standby_n_pin}),
    .q       (pins_s)
  );

  assign {sclk_s, cs_n_s, din_s, run_s} = pins_s;

  logic                         sclk_d_ff;
  asp_pkg::asp_phase_t          ph_ff,     nxt_ph;
  logic [CW-1:0]                cnt_ff,    nxt_cnt;
  logic [DW-1:0]                sh_in_ff,  nxt_sh_in;
  logic [DW-1:0]                sh_out_ff, nxt_sh_out;
  logic [asp_pkg::CMD_W-1:0]    comm_ff,   nxt_comm;
  asp_pkg::asp_cfg_t            nxt_cfg;
  logic [DW-1:0]                data_ff,   nxt_data;
  logic                         nxt_rdy_n;
  logic                         rd_done;
  logic                         rise;
  logic                         fall;
  logic [asp_pkg::SEL_W-1:0]    sel;

  assign rise = sclk_s & ~sclk_d_ff;
  assign fall = ~sclk_s & sclk_d_ff;
  assign sel  = comm_ff[asp_pkg::SEL_LSB +: asp_pkg::SEL_W];

  function automatic logic [DW-1:0] rd_mux(
    input logic [asp_pkg::SEL_W-1:0] s,
    input asp_pkg::asp_cfg_t         c,
    input logic [DW-1:0]             d,
    input logic                      r
  );
    logic [DW-1:0] v;
    v = '0;
    unique case (s)
      asp_pkg::SEL_COMM:   v = {r, {(DW-1){1'b0}}};
      asp_pkg::SEL_DATA:   v = d;
      asp_pkg::SEL_MODE:   v = c.mode;
      asp_pkg::SEL_FILTER: v = c.filter;
      asp_pkg::SEL_DAC:    v = c.dac;
      asp_pkg::SEL_CAL:    v = c.cal;
      default:             v = '0;
    endcase
    return v;
  endfunction : rd_mux

  function automatic logic writable(input logic [asp_pkg::SEL_W-1:0] s);
    return (s == asp_pkg::SEL_MODE) || (s == asp_pkg::SEL_FILTER) ||
           (s == asp_pkg::SEL_DAC)  || (s == asp_pkg::SEL_CAL);
  endfunction : writable

  // Serial engine
  always_comb
  begin
    logic [asp_pkg::CMD_W-1:0] byte_in;
    logic [DW-1:0]             word_in;
    byte_in    = {sh_in_ff[asp_pkg::CMD_W-2:0], din_s};
    word_in    = {sh_in_ff[DW-2:0], din_s};
    nxt_ph     = ph_ff;
    nxt_cnt    = cnt_ff;
    nxt_sh_in  = sh_in_ff;
    nxt_sh_out = sh_out_ff;
    nxt_comm   = comm_ff;
    nxt_cfg    = cfg_ff;
    rd_done    = 1'b0;
    // Whole engine frozen in standby; nothing is cleared
    if (run_s) // see RULE1 see RULE2
    begin
      if (cs_n_s) // see RULE3 see RULE5
      begin
        nxt_ph  = asp_pkg::PH_CMD;
        nxt_cnt = '0;
      end
      else // see RULE4
      begin
        // First falling edge of a read presents the loaded MSB; no shift yet
        if (fall && ph_ff == asp_pkg::PH_RD && cnt_ff != '0)
        begin
          nxt_sh_out = {sh_out_ff[DW-2:0], 1'b0}; // see RULE13
        end
        if (rise)
        begin
          nxt_cnt   = cnt_ff + 1'b1; // see RULE13
          nxt_sh_in = word_in;
          unique case (ph_ff)
            asp_pkg::PH_CMD:
            begin
              if (cnt_ff == CW'(asp_pkg::CMD_W - 1))
              begin
                nxt_comm = byte_in; // see RULE12
                nxt_cnt  = '0;
                if (byte_in[asp_pkg::RW_BIT])
                begin
                  nxt_ph     = asp_pkg::PH_RD;
                  nxt_sh_out = rd_mux(
                    byte_in[asp_pkg::SEL_LSB +: asp_pkg::SEL_W],
                    cfg_ff, data_ff, rdy_n_ff); // see RULE11
                end
                else if (writable(
                  byte_in[asp_pkg::SEL_LSB +: asp_pkg::SEL_W]))
                begin
                  nxt_ph = asp_pkg::PH_WR;
                end
              end
            end
            asp_pkg::PH_RD:
            begin
              if (cnt_ff == CW'(DW - 1))
              begin
                nxt_ph  = asp_pkg::PH_CMD;
                nxt_cnt = '0;
                rd_done = (sel == asp_pkg::SEL_DATA); // see RULE7
              end
            end
            asp_pkg::PH_WR:
            begin
              if (cnt_ff == CW'(DW - 1))
              begin
                nxt_ph  = asp_pkg::PH_CMD;
                nxt_cnt = '0;
                unique case (sel) // see RULE12
                  asp_pkg::SEL_MODE:   nxt_cfg.mode   = word_in;
                  asp_pkg::SEL_FILTER: nxt_cfg.filter = word_in;
                  asp_pkg::SEL_DAC:    nxt_cfg.dac    = word_in;
                  asp_pkg::SEL_CAL:    nxt_cfg.cal    = word_in;
                  default:             nxt_cfg        = cfg_ff;
                endcase
              end
            end
            default:
            begin
              nxt_ph  = asp_pkg::PH_CMD;
              nxt_cnt = '0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_d_ff  <= 1'b1;
      ph_ff      <= asp_pkg::PH_CMD;
      cnt_ff     <= '0;
      sh_in_ff   <= '0;
      sh_out_ff  <= '0;
      comm_ff    <= asp_pkg::COMM_RST;
      cfg_ff     <= {asp_pkg::MODE_RST, asp_pkg::FILT_RST,
                     asp_pkg::DAC_RST, asp_pkg::CAL_RST};
      dout_ff    <= 1'b0;
      dout_oe_ff <= 1'b0;
      run_ff     <= 1'b0;
    end
    else
    begin
      sclk_d_ff  <= sclk_s;
      ph_ff      <= nxt_ph;
      cnt_ff     <= nxt_cnt;
      sh_in_ff   <= nxt_sh_in;
      sh_out_ff  <= nxt_sh_out;
      comm_ff    <= nxt_comm;
      cfg_ff     <= nxt_cfg;
      dout_ff    <= sh_out_ff[DW-1]; // see RULE11
      dout_oe_ff <= ~cs_n_s;
      run_ff     <= run_s; // see RULE1
    end
  end

  // Result register and ready flag; new data beats a finishing read
  always_comb
  begin
    nxt_data  = data_ff;
    nxt_rdy_n = rdy_n_ff;
    if (run_s) // see RULE1
    begin
      if (conv.pend || conv.cal_start) // see RULE8 see RULE10
      begin
        nxt_rdy_n = 1'b1;
      end
      else if (conv.valid)
      begin
        nxt_data  = conv.data;
        nxt_rdy_n = 1'b0; // see RULE6 see RULE8
      end
      else if (conv.cal_done)
      begin
        nxt_rdy_n = 1'b0; // see RULE10
      end
      else if (rd_done)
      begin
        nxt_rdy_n = 1'b1; // see RULE7
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      data_ff  <= asp_pkg::DATA_RST;
      rdy_n_ff <= 1'b1;
    end
    else
    begin
      data_ff  <= nxt_data;
      rdy_n_ff <= nxt_rdy_n;
    end
  end

  stby_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !run_s |=> $stable(cfg_ff) && $stable(ph_ff) && $stable(rdy_n_ff)
              && $stable(data_ff)) // see RULE1 see RULE2
    else $error("State moved during standby");

  cs_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    run_s && cs_n_s |=> ph_ff == asp_pkg::PH_CMD && cnt_ff == '0)
    // see RULE3
    else $error("Port not idle while deselected");

  bit_step_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    run_s && !cs_n_s && rise && ph_ff == asp_pkg::PH_RD
      && cnt_ff < CW'(DW - 1)
      |=> cnt_ff == $past(cnt_ff) + 1'b1) // see RULE13
    else $error("Bit count did not advance");

  rdy_pend_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    run_s && conv.pend |=> rdy_n_ff ##1 (rdy_n_ff || $past(conv.valid)))
    // see RULE8
    else $error("Ready not high before update");

  rdy_new_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    run_s && conv.valid && !conv.pend && !conv.cal_start
      |=> !rdy_n_ff && data_ff == $past(conv.data)) // see RULE6
    else $error("Fresh result not flagged");

  rdy_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    run_s && rd_done && !conv.valid && !conv.cal_done |=> rdy_n_ff)
    // see RULE7
    else $error("Ready low after full read");

  cal_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    run_s && conv.cal_start |=> rdy_n_ff) // see RULE10
    else $error("Ready low at calibration start");

  rd_load_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(run_s) && ph_ff == asp_pkg::PH_RD && $past(ph_ff) == asp_pkg::PH_CMD
      && sel == asp_pkg::SEL_DATA |-> sh_out_ff == $past(data_ff))
    // see RULE11
    else $error("Output shifter not loaded from data");

  wr_mode_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    run_s && !cs_n_s && rise && ph_ff == asp_pkg::PH_WR
      && cnt_ff == CW'(DW - 1) && sel == asp_pkg::SEL_MODE
      |=> cfg_ff.mode == $past({sh_in_ff[DW-2:0], din_s})) // see RULE12
    else $error("Mode word not written");

  read_done_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    rd_done);
  write_done_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    ph_ff == asp_pkg::PH_WR ##1 ph_ff == asp_pkg::PH_CMD);
  cal_cycle_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    conv.cal_start ##[1:200] conv.cal_done);
  standby_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    run_s ##1 !run_s ##1 run_s);

endmodule : asp_port

// ===== bench/asp_host.sv
// Purpose: Serial master model driving the converter serial port.
// Assumes: Clock idles high; device samples din on rising edges.
// Notes:   Runs on its own time base, unrelated to clk_sys.
`timescale 1ns/1ps
module asp_host (
  input  wire logic tie_cs,
  input  wire logic dout,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  localparam realtime HALF = 62.5;
  logic cs_q;

  assign cs_n = tie_cs ? 1'b0 : cs_q;

  initial
  begin
    sclk = 1'b1;
    cs_q = 1'b1;
    din  = 1'b0;
  end

  // Clock stands still between frames
  task automatic xfer(input logic [31:0] tx, input int nbits,
                      output logic [23:0] rx);
    rx   = '0;
    cs_q = 1'b0;
    #(HALF);
    for (int i = 31; i > 31 - nbits; i--)
    begin
      sclk = 1'b0;
      din  = tx[i];
      #(HALF);
      sclk = 1'b1;
      rx   = {rx[22:0], dout};
      #(HALF);
    end
    cs_q = 1'b1;
    // Released line must not keep its last value
    din  = ~din;
    #(HALF);
  endtask : xfer
endmodule : asp_host

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the converter serial port.
// Assumes: Host model owns the serial pins; bench drives conv events.
// Notes:   Expected values come from a small model held in arrays.
`timescale 1ns/1ps
module tb_top;
  logic               clk_sys, rstn, standby_n, tie_cs;
  logic               sclk, cs_n, din, dout, dout_oe, rdy_n, run;
  asp_pkg::asp_conv_t conv;
  asp_pkg::asp_cfg_t  cfg;
  int                 fail_count, n_compared, seed;
  logic [23:0]        exp_reg [8];
  logic [23:0]        exp_data, rx, w;
  logic [31:0]        r;
  logic               exp_rdy;

  asp_port asp_port_i (.clk_sys(clk_sys), .rstn(rstn), .sclk_pin(sclk),
    .cs_n_pin(cs_n), .din_pin(din), .standby_n_pin(standby_n), .conv(conv),
    .dout_ff(dout), .dout_oe_ff(dout_oe), .rdy_n_ff(rdy_n), .run_ff(run),
    .cfg_ff(cfg));
  asp_host asp_host_i (.tie_cs(tie_cs), .dout(dout), .sclk(sclk),
    .cs_n(cs_n), .din(din));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask : check

  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : clks

  // Flags in struct order: pend, valid, cal_start, cal_done
  task automatic pulse(input logic [3:0] f, input logic [23:0] d);
    clks(1);
    conv = {f, d};
    clks(1);
    conv = '0;
    clks(2);
  endtask : pulse

  task automatic rw(input int s, input logic rd, input logic [23:0] d,
                    input int nbits);
    asp_host_i.xfer({1'b0, rd, 3'h0, s[2:0], d}, nbits, rx);
    clks(6);
  endtask : rw

  function automatic logic [23:0] get_cfg(input int s);
    case (s)
      2: return cfg.mode;
      3: return cfg.filter;
      4: return cfg.dac;
      5: return cfg.cal;
      default: return 24'h000000;
    endcase
  endfunction : get_cfg

  function automatic logic [23:0] exp_read(input int s);
    if (s == 0) return {exp_rdy, 23'h000000};
    if (s == 1) return exp_data;
    return exp_reg[s];
  endfunction : exp_read

  task automatic report_and_stop();
    $display("compared=%0d failed=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    rstn = 1'b0; standby_n = 1'b1; tie_cs = 1'b0; conv = '0;
    seed = 32'hc6c0; fail_count = 0; n_compared = 0;
    exp_rdy = 1'b1; exp_data = asp_pkg::DATA_RST;
    foreach (exp_reg[i]) exp_reg[i] = 24'h000000;
    exp_reg[2] = asp_pkg::MODE_RST; exp_reg[3] = asp_pkg::FILT_RST;
    exp_reg[4] = asp_pkg::DAC_RST;  exp_reg[5] = asp_pkg::CAL_RST;
    repeat (6) @(posedge clk_sys);
    #1 rstn = 1'b1;
    clks(6);
    check({21'h0, rdy_n, dout_oe, run}, 24'h000005);
    for (int s = 2; s < 6; s++) check(get_cfg(s), exp_reg[s]);
    $display("test reset done");

    for (int s = 2; s < 6; s++)
    begin
      r = $random(seed);
      rw(s, 1'b0, r[23:0], 32);
      exp_reg[s] = r[23:0];
      check(get_cfg(s), exp_reg[s]);
    end
    for (int s = 0; s < 8; s++)
      if (s != 1)
      begin
        rw(s, 1'b1, 24'h000000, 32);
        check(rx, exp_read(s));
      end
    $display("test registers done");

    pulse(4'h8, 24'h000000);
    check({23'h0, rdy_n}, 24'h000001);
    r = $random(seed);
    pulse(4'h4, r[23:0]);
    exp_data = r[23:0]; exp_rdy = 1'b0;
    check({23'h0, rdy_n}, 24'h000000);
    rw(0, 1'b1, 24'h000000, 32);
    check(rx, exp_read(0));
    rw(1, 1'b1, 24'h000000, 20);
    check({23'h0, rdy_n}, 24'h000000);
    pulse(4'h8, 24'h000000);
    check({23'h0, rdy_n}, 24'h000001);
    r = $random(seed);
    pulse(4'h4, r[23:0]);
    exp_data = r[23:0];
    check({23'h0, rdy_n}, 24'h000000);
    rw(1, 1'b1, 24'h000000, 32);
    exp_rdy = 1'b1;
    check(rx, exp_data);
    check({23'h0, rdy_n}, 24'h000001);
    $display("test conversion done");

    pulse(4'h2, 24'h000000);
    check({23'h0, rdy_n}, 24'h000001);
    pulse(4'h1, 24'h000000);
    exp_rdy = 1'b0;
    check({23'h0, rdy_n}, 24'h000000);
    $display("test calibration done");

    standby_n = 1'b0;
    clks(5);
    check({23'h0, run}, 24'h000000);
    r = $random(seed);
    rw(2, 1'b0, r[23:0], 32);
    check(cfg.mode, exp_reg[2]);
    pulse(4'h2, 24'h000000);
    check({23'h0, rdy_n}, 24'h000000);
    standby_n = 1'b1;
    clks(5);
    check({23'h0, run}, 24'h000001);
    rw(2, 1'b1, 24'h000000, 32);
    check(rx, exp_reg[2]);
    $display("test standby done");

    tie_cs = 1'b1;
    clks(6);
    check({23'h0, dout_oe}, 24'h000001);
    r = $random(seed);
    rw(3, 1'b0, r[23:0], 32);
    exp_reg[3] = r[23:0];
    rw(3, 1'b1, 24'h000000, 32);
    check(rx, exp_reg[3]);
    tie_cs = 1'b0;
    clks(6);
    $display("test three wire done");
    report_and_stop();
  end
endmodule : tb_top
